// ### hdl/iba_pkg.sv
// Package: constants, tables and carrier types of the two-wire rate and address block
package iba_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] IBA_OFF_OWN_ADDR  = 8'h00;
  localparam logic [7:0] IBA_OFF_RATE_DIV  = 8'h01;
  localparam logic [7:0] IBA_OFF_CTRL      = 8'h02;
  localparam logic [7:0] IBA_OFF_IRQ_STAT  = 8'h03;
  localparam logic [7:0] IBA_OFF_IRQ_CLR   = 8'h04;
  localparam logic [7:0] IBA_OFF_IRQ_EN    = 8'h05;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IBA_ADDR_LSB      = 1;
  localparam int IBA_RATE_MULTIPLIER_SELECT_HI       = 7;
  localparam int IBA_RATE_MULTIPLIER_SELECT_LO       = 6;
  localparam int IBA_RIDX_HI       = 5;
  localparam int IBA_RIDX_LO       = 0;
  localparam int IBA_CTRL_EN       = 7;
  localparam int IBA_CTRL_MASTER   = 5;
  localparam int IBA_CTRL_SDA_BIT  = 0;
  localparam int IBA_EV_ADDR_HIT   = 0;
  localparam int IBA_EV_ARB_LOST   = 1;
  localparam int IBA_STAT_BUSY     = 7;
  localparam int IBA_NEV           = 2;

  // ----------------------------------------------------------------
  // Encodings, reset values, counts
  // ----------------------------------------------------------------
  localparam logic [1:0] IBA_MUL_X1    = 2'h0;
  localparam logic [1:0] IBA_MUL_X2    = 2'h1;
  localparam logic [1:0] IBA_MUL_X4    = 2'h2;
  localparam logic [7:0] IBA_REG_RST   = 8'h00;
  localparam logic [3:0] IBA_ADDR_BITS = 4'h8;

  // Serial clock divider per rate index
  localparam logic [11:0] IBA_SCL_DIV [64] = '{
    12'h014, 12'h016, 12'h018, 12'h01A, 12'h01C, 12'h01E, 12'h022, 12'h028,
    12'h01C, 12'h020, 12'h024, 12'h028, 12'h02C, 12'h030, 12'h038, 12'h044,
    12'h030, 12'h038, 12'h040, 12'h048, 12'h050, 12'h058, 12'h068, 12'h080,
    12'h050, 12'h060, 12'h070, 12'h080, 12'h090, 12'h0A0, 12'h0C0, 12'h0F0,
    12'h0A0, 12'h0C0, 12'h0E0, 12'h100, 12'h120, 12'h140, 12'h180, 12'h1E0,
    12'h140, 12'h180, 12'h1C0, 12'h200, 12'h240, 12'h280, 12'h300, 12'h3C0,
    12'h280, 12'h300, 12'h380, 12'h400, 12'h480, 12'h500, 12'h600, 12'h780,
    12'h500, 12'h600, 12'h700, 12'h800, 12'h900, 12'hA00, 12'hC00, 12'hF00};

  // Data hold count per rate index, in bus clock periods
  localparam logic [9:0] IBA_SDA_HOLD [64] = '{
    10'h007, 10'h007, 10'h008, 10'h008, 10'h009, 10'h009, 10'h00A, 10'h00A,
    10'h007, 10'h007, 10'h009, 10'h009, 10'h00B, 10'h00B, 10'h00D, 10'h00D,
    10'h009, 10'h009, 10'h00D, 10'h00D, 10'h011, 10'h011, 10'h015, 10'h015,
    10'h009, 10'h009, 10'h011, 10'h011, 10'h019, 10'h019, 10'h021, 10'h021,
    10'h011, 10'h011, 10'h021, 10'h021, 10'h031, 10'h031, 10'h041, 10'h041,
    10'h021, 10'h021, 10'h041, 10'h041, 10'h061, 10'h061, 10'h081, 10'h081,
    10'h041, 10'h041, 10'h081, 10'h081, 10'h0C1, 10'h0C1, 10'h101, 10'h101,
    10'h081, 10'h081, 10'h101, 10'h101, 10'h181, 10'h181, 10'h201, 10'h201};

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } iba_reg_req_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } iba_pin_in_s;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } iba_pin_out_s;

  typedef enum logic [1:0] {
    IBA_SL_IDLE = 2'b00,
    IBA_SL_ADDR = 2'b01,
    IBA_SL_ACK  = 2'b10,
    IBA_SL_HIT  = 2'b11
  } iba_slave_e;

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
  } iba_sync_s;

  typedef struct packed {
    logic [6:0]         own_addr;
    logic [7:0]         rate;
    logic               en;
    logic               master;
    logic               sda_bit;
    logic [IBA_NEV-1:0] irq_stat;
    logic [IBA_NEV-1:0] irq_en;
    logic               busy;
    iba_slave_e         sl;
    logic [7:0]         shreg;
    logic [3:0]         bitcnt;
    logic [13:0]        div_cnt;
    logic               scl_low;
    logic [9:0]         hold_cnt;
    logic               hold_run;
    logic               sda_low;
    logic               irq;
    logic [7:0]         rdata;
  } iba_core_s;

  typedef struct packed {
    iba_sync_s sync;
    iba_core_s core;
  } iba_state_s;

  localparam iba_core_s IBA_CORE_RST = '0;
  localparam iba_sync_s IBA_SYNC_RST = '1;

endpackage

// ### hdl/iba_top.sv
// Two-wire bus controller: own address, bit rate, data hold and power mode handling
// Operation
// [R1] Serial rate reaches bus clock divided by twenty at the smallest setting.
// [R2] Sixty-four serial clock frequencies are selectable through the rate index.
// [R3] Behaviour is the same in normal and debug monitor modes.
// [R4] In wait mode the block keeps working and its interrupt can wake.
// [R5] In stop3 all bus activity stops.
// [R6] A plain stop leaves all register contents untouched. Code clears the busy flag while stop3_mode is held.
// [R7] Stop2 or stop1 returns every register to its reset value.
// [R8] As slave, answer only the address held in the own-address register.
// [R9] Multiplier code selects factor one, two or four; code three reserved.
// [R10] Six-bit rate index selects both clock divider and hold count.
// [R11] Serial rate is bus clock over multiplier times divider.
// [R12] Data line changes only hold-count clocks after each serial clock fall.
// [R13] Software changes multiplier and index together for a different hold count.
// [R14] Lost arbitration raises an interrupt and drops to slave operation.
// [R15] Own address called on the bus raises an interrupt.
// [R16] Bus busy is detected from start to stop and reported.
// [R17] Fixed table maps each rate index to divider and hold count.
// [R18] Own address sits in bits seven to one; bit zero reads zero.
// [R19] Reserved multiplier code acts as factor one.
`timescale 1ns/10ps

module iba_top
  import iba_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  input  wire iba_reg_req_s  reg_req,
  output logic [7:0]         reg_rdata,
  input  wire logic          stop3_mode,
  input  wire logic          deep_stop,
  input  wire iba_pin_in_s   pin_in,
  output iba_pin_out_s       pin_out,
  output logic               bus_busy,
  output logic               irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  iba_state_s         st_ff;
  iba_state_s         nxt_st;
  logic               scl_rise;
  logic               scl_fall;
  logic               sda_rise;
  logic               sda_fall;
  logic               active;
  logic               start_c;
  logic               stop_c;
  logic [5:0]         ridx;
  logic [13:0]        div14;
  logic [13:0]        total;
  logic [13:0]        half;
  logic [IBA_NEV-1:0] ev;
  logic [IBA_NEV-1:0] clr;
  logic               want_low;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    ev     = '0;
    clr    = '0;

    // Pins are asynchronous to ref_clk
    nxt_st.sync.scl1 = pin_in.scl;
    nxt_st.sync.scl2 = st_ff.sync.scl1;
    nxt_st.sync.scl3 = st_ff.sync.scl2;
    nxt_st.sync.sda1 = pin_in.sda;
    nxt_st.sync.sda2 = st_ff.sync.sda1;
    nxt_st.sync.sda3 = st_ff.sync.sda2;

    scl_rise = st_ff.sync.scl2 & ~st_ff.sync.scl3;
    scl_fall = ~st_ff.sync.scl2 & st_ff.sync.scl3;
    sda_rise = st_ff.sync.sda2 & ~st_ff.sync.sda3;
    sda_fall = ~st_ff.sync.sda2 & st_ff.sync.sda3;

    // No mode input for debug monitor: behaviour cannot differ
    active  = st_ff.core.en & ~stop3_mode; // [R5] [R3]
    start_c = active & st_ff.sync.scl2 & st_ff.sync.scl3 & sda_fall;
    stop_c  = active & st_ff.sync.scl2 & st_ff.sync.scl3 & sda_rise;

    ridx  = st_ff.core.rate[IBA_RIDX_HI:IBA_RIDX_LO]; // [R10]
    div14 = {2'b00, IBA_SCL_DIV[ridx]}; // [R17] [R2]
    case (st_ff.core.rate[IBA_RATE_MULTIPLIER_SELECT_HI:IBA_RATE_MULTIPLIER_SELECT_LO]) // [R9]
      IBA_MUL_X1: total = div14;
      IBA_MUL_X2: total = div14 << 1;
      IBA_MUL_X4: total = div14 << 2;
      default:    total = div14; // [R19]
    endcase
    half = total >> 1; // [R11]

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    if (reg_req.wr) begin
      case (reg_req.addr)
        IBA_OFF_OWN_ADDR: begin
          nxt_st.core.own_addr = reg_req.wdata[7:IBA_ADDR_LSB]; // [R18]
        end
        IBA_OFF_RATE_DIV: begin
          nxt_st.core.rate = reg_req.wdata;
        end
        IBA_OFF_CTRL: begin
          nxt_st.core.en      = reg_req.wdata[IBA_CTRL_EN];
          nxt_st.core.master  = reg_req.wdata[IBA_CTRL_MASTER];
          nxt_st.core.sda_bit = reg_req.wdata[IBA_CTRL_SDA_BIT];
        end
        IBA_OFF_IRQ_CLR: begin
          clr = reg_req.wdata[IBA_NEV-1:0];
        end
        IBA_OFF_IRQ_EN: begin
          nxt_st.core.irq_en = reg_req.wdata[IBA_NEV-1:0];
        end
        default: begin
        end
      endcase
    end

    // --------------------------------------------------------------
    // Bus busy
    // --------------------------------------------------------------
    if (start_c) begin
      nxt_st.core.busy = 1'b1; // [R16]
    end else if (stop_c || !active) begin
      nxt_st.core.busy = 1'b0; // [R16]
    end

    // --------------------------------------------------------------
    // Slave address recognition
    // --------------------------------------------------------------
    if (!active) begin
      nxt_st.core.sl = IBA_SL_IDLE;
    end else if (start_c) begin
      nxt_st.core.sl     = IBA_SL_ADDR;
      nxt_st.core.bitcnt = 4'h0;
    end else if (stop_c) begin
      nxt_st.core.sl = IBA_SL_IDLE;
    end else begin
      case (st_ff.core.sl)
        IBA_SL_IDLE: begin
        end
        IBA_SL_ADDR: begin
          if (scl_rise) begin
            nxt_st.core.shreg  = {st_ff.core.shreg[6:0], st_ff.sync.sda2};
            nxt_st.core.bitcnt = 4'(st_ff.core.bitcnt + 4'h1);
          end else if (scl_fall && st_ff.core.bitcnt == IBA_ADDR_BITS) begin
            if (st_ff.core.shreg[7:1] == st_ff.core.own_addr) begin // [R8]
              nxt_st.core.sl       = IBA_SL_ACK;
              ev[IBA_EV_ADDR_HIT]  = 1'b1; // [R15]
            end else begin
              nxt_st.core.sl = IBA_SL_IDLE;
            end
          end
        end
        IBA_SL_ACK: begin
          if (scl_fall) begin
            nxt_st.core.sl = IBA_SL_HIT;
          end
        end
        IBA_SL_HIT: begin
        end
        default: begin
          nxt_st.core.sl = IBA_SL_IDLE;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Serial clock generation
    // --------------------------------------------------------------
    // Fixed half periods, no stretch wait: keeps the rate exact
    if (active && st_ff.core.master) begin
      if (st_ff.core.div_cnt >= 14'(half - 14'h0001)) begin
        nxt_st.core.div_cnt = 14'h0000;
        nxt_st.core.scl_low = ~st_ff.core.scl_low; // [R11] [R1]
      end else begin
        nxt_st.core.div_cnt = 14'(st_ff.core.div_cnt + 14'h0001);
      end
    end else begin
      nxt_st.core.div_cnt = 14'h0000;
      nxt_st.core.scl_low = 1'b0;
    end

    // --------------------------------------------------------------
    // Arbitration
    // --------------------------------------------------------------
    // Released SDA seen low at clock rise: another master owns the bus
    if (active && st_ff.core.master && !st_ff.core.sda_low && scl_rise && !st_ff.sync.sda2) begin
      nxt_st.core.master   = 1'b0; // [R14]
      nxt_st.core.scl_low  = 1'b0;
      nxt_st.core.div_cnt  = 14'h0000;
      ev[IBA_EV_ARB_LOST]  = 1'b1; // [R14]
    end

    // --------------------------------------------------------------
    // Data line drive with hold delay
    // --------------------------------------------------------------
    want_low = (nxt_st.core.master & ~nxt_st.core.sda_bit) | (nxt_st.core.sl == IBA_SL_ACK);
    if (!active || ev[IBA_EV_ARB_LOST]) begin
      nxt_st.core.hold_run = 1'b0;
      nxt_st.core.sda_low  = 1'b0;
    end else if (scl_fall) begin
      nxt_st.core.hold_run = 1'b1;
      nxt_st.core.hold_cnt = 10'(IBA_SDA_HOLD[ridx] - 10'h001); // [R12] [R17]
    end else if (st_ff.core.hold_run) begin
      if (st_ff.core.hold_cnt == 10'h000) begin
        nxt_st.core.hold_run = 1'b0;
        nxt_st.core.sda_low  = want_low; // [R12]
      end else begin
        nxt_st.core.hold_cnt = 10'(st_ff.core.hold_cnt - 10'h001);
      end
    end else if (st_ff.core.master && st_ff.sync.scl2 && !st_ff.core.scl_low) begin
      // Clock high and no hold pending: start and stop conditions
      nxt_st.core.sda_low = want_low;
    end

    // --------------------------------------------------------------
    // Interrupts
    // --------------------------------------------------------------
    // Set beats a clear in the same cycle
    nxt_st.core.irq_stat = (st_ff.core.irq_stat & ~clr) | ev;
    nxt_st.core.irq      = |(nxt_st.core.irq_stat & nxt_st.core.irq_en); // [R4]

    // --------------------------------------------------------------
    // Register reads
    // --------------------------------------------------------------
    nxt_st.core.rdata = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        IBA_OFF_OWN_ADDR: nxt_st.core.rdata = {st_ff.core.own_addr, 1'b0}; // [R18]
        IBA_OFF_RATE_DIV: nxt_st.core.rdata = st_ff.core.rate;
        IBA_OFF_CTRL: begin
          nxt_st.core.rdata[IBA_CTRL_EN]      = st_ff.core.en;
          nxt_st.core.rdata[IBA_CTRL_MASTER]  = st_ff.core.master;
          nxt_st.core.rdata[IBA_CTRL_SDA_BIT] = st_ff.core.sda_bit;
        end
        IBA_OFF_IRQ_STAT: begin
          nxt_st.core.rdata[IBA_NEV-1:0]   = st_ff.core.irq_stat;
          nxt_st.core.rdata[IBA_STAT_BUSY] = st_ff.core.busy; // [R16]
        end
        IBA_OFF_IRQ_EN: nxt_st.core.rdata[IBA_NEV-1:0] = st_ff.core.irq_en;
        default:        nxt_st.core.rdata = 8'h00;
      endcase
    end

    // stop3_mode freezes activity and clears busy; other registers are kept
    if (deep_stop) begin
      nxt_st.core = IBA_CORE_RST; // [R7] [R6]
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff.sync <= IBA_SYNC_RST;
      st_ff.core <= IBA_CORE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain: only ever pull low
  assign pin_out.scl_o  = 1'b0;
  assign pin_out.scl_oe = st_ff.core.scl_low;
  assign pin_out.sda_o  = 1'b0;
  assign pin_out.sda_oe = st_ff.core.sda_low;
  assign reg_rdata      = st_ff.core.rdata;
  assign bus_busy       = st_ff.core.busy;
  assign irq            = st_ff.core.irq;

endmodule

// ### verif/iba_properties.sv
// Checker: concurrent properties of the rate and address block
`timescale 1ns/10ps

module iba_props
  import iba_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         nrst,
  input wire iba_reg_req_s reg_req,
  input wire logic [7:0]   reg_rdata,
  input wire logic         stop3_mode,
  input wire logic         deep_stop,
  input wire iba_pin_in_s  pin_in,
  input wire iba_pin_out_s pin_out,
  input wire logic         bus_busy,
  input wire logic         irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  logic [7:0] rate_ff;
  logic [1:0] ien_ff;
  logic [9:0] low_ff;

  // Shadows of written registers, cleared by deep stop too
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rate_ff <= 8'h00;
      ien_ff  <= 2'h0;
    end else if (deep_stop) begin
      rate_ff <= 8'h00;
      ien_ff  <= 2'h0;
    end else if (reg_req.wr && reg_req.addr == IBA_OFF_RATE_DIV) begin
      rate_ff <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == IBA_OFF_IRQ_EN) begin
      ien_ff <= reg_req.wdata[1:0];
    end
  end

  // Length of the current low phase; saturates, never wraps
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_ff <= 10'h000;
    end else if (pin_in.scl) begin
      low_ff <= 10'h000;
    end else if (low_ff != 10'h3FF) begin
      low_ff <= low_ff + 10'h001;
    end
  end

  sequence s_frozen;
    stop3_mode [*2];
  endsequence
  sequence s_go;
    reg_req.wr && reg_req.addr == IBA_OFF_CTRL && reg_req.wdata[7] && reg_req.wdata[5] && !pin_out.scl_oe;
  endsequence

  read_rate_a: assert property (reg_req.rd && reg_req.addr == IBA_OFF_RATE_DIV && !deep_stop |=>
    reg_rdata == rate_ff) else $error("rate read differs");
  addr_lsb_a: assert property (reg_req.rd && reg_req.addr == IBA_OFF_OWN_ADDR |=> !reg_rdata[0])
    else $error("address bit 0 not zero");
  irq_mask_a: assert property (irq |-> (ien_ff | $past(ien_ff)) != 2'h0)
    else $error("irq while masked");
  deep_reset_a: assert property (deep_stop |=> reg_rdata == 8'h00 && !irq && !bus_busy && !pin_out.scl_oe)
    else $error("deep stop left state");
  stop3_idle_a: assert property (s_frozen |-> !pin_out.scl_oe && !pin_out.sda_oe)
    else $error("bus driven in stop3");
  sda_hold_a: assert property (!pin_in.scl && $changed(pin_out.sda_oe) &&
    !$past(stop3_mode) && !$past(deep_stop) |-> low_ff >= IBA_SDA_HOLD[rate_ff[5:0]])
    else $error("data moved inside hold");
  busy_start_a: assert property ($rose(bus_busy) |->
    !$past(pin_in.sda, 1) || !$past(pin_in.sda, 2) || !$past(pin_in.sda, 3)) else $error("busy without start");
  scl_first_a: assert property (s_go |=> !pin_out.scl_oe [*8])
    else $error("clock phase too short");
endmodule

bind iba_top iba_props u_iba_props (.ref_clk, .nrst, .reg_req, .reg_rdata, .stop3_mode, .deep_stop, .pin_in,
  .pin_out, .bus_busy, .irq);

// ### verif/iba_peer.sv
// Model of another device on the shared two-wire bus
`timescale 1ns/10ps

module iba_peer
  import iba_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire iba_pin_out_s pin_out,
  output iba_pin_in_s       pin_in
);
  localparam int PH = 40;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;

  // Open drain with pull-ups: a released line reads high
  assign pin_in.scl = !(pin_out.scl_oe || scl_low);
  assign pin_in.sda = !(pin_out.sda_oe || sda_low);

  // Data lags the clock so bit changes never look like START or STOP
  task automatic drive(input logic c, input logic d);
    @(posedge ref_clk);
    scl_low <= !c;
    repeat (4) @(posedge ref_clk);
    sda_low <= !d;
    repeat (PH - 5) @(posedge ref_clk);
  endtask

  task automatic hold_sda(input logic v);
    @(posedge ref_clk);
    sda_low <= v;
  endtask

  // START, address byte, answer clock (dly: cycles to ACK, 0 if none), STOP
  task automatic call(input logic [7:0] b, output int dly);
    dly = 0;
    drive(1'b1, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      drive(1'b0, b[i]);
      drive(1'b1, b[i]);
    end
    @(posedge ref_clk);
    scl_low <= 1'b1;
    for (int k = 1; k < PH; k++) begin
      @(posedge ref_clk);
      if (k == 4) sda_low <= 1'b0;
      if (dly == 0 && pin_out.sda_oe) dly = k;
    end
    drive(1'b1, 1'b1);
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  endtask
endmodule

// ### verif/tb_top.sv
// Self-checking testbench of the two-wire rate and address block
`timescale 1ns/10ps

module tb_top
  import iba_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         nrst = 1'b0;
  iba_reg_req_s reg_req = '0;
  logic         stop3_mode = 1'b0;
  logic         deep_stop = 1'b0;
  logic [7:0]   reg_rdata;
  iba_pin_in_s  pin_in;
  iba_pin_out_s pin_out;
  logic         bus_busy;
  logic         irq;
  int           miscompares = 0;
  int           checks = 0;
  int           dly;
  logic [6:0]   own;
  logic [7:0]   rv;

  initial forever #10 ref_clk = ~ref_clk;

  iba_top u_iba_top (.ref_clk, .nrst, .reg_req, .reg_rdata, .stop3_mode, .deep_stop, .pin_in, .pin_out,
    .bus_busy, .irq);
  iba_peer u_iba_peer (.ref_clk, .pin_out, .pin_in);

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    #1 cmp8(reg_rdata, e);
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e) begin
      miscompares++;
      $display("[ERR] %0t value %h, expected %h", $time, got, e);
    end
  endtask
  task automatic cmpn(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] %0t count %0d, expected %0d to %0d", $time, got, lo, hi);
    end
  endtask
  function automatic int half(input logic [7:0] r);
    return (r[7:6] == 2'h1 ? 2 : r[7:6] == 2'h2 ? 4 : 1) * int'(IBA_SCL_DIV[r[5:0]]) / 2;
  endfunction
  task automatic wait_oe(input logic v);
    for (int i = 0; i < 9000 && pin_out.scl_oe !== v; i++) begin
      @(posedge ref_clk);
    end
  endtask
  // Master clock: one high and one low phase measured
  task automatic rate_run(input logic [7:0] r);
    int n;
    wr(IBA_OFF_RATE_DIV, r);
    wr(IBA_OFF_CTRL, 8'hA1);
    wait_oe(1'b1);
    for (int k = 0; k < 2; k++) begin
      for (n = 0; n < 9000 && pin_out.scl_oe === !k[0]; n++) begin
        @(posedge ref_clk);
      end
      cmpn(n, half(r), half(r));
    end
    wr(IBA_OFF_CTRL, 8'h00);
  endtask
  task automatic all_zero();
    wr(IBA_OFF_IRQ_STAT, 8'hFF);
    wr(8'h07, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      chk(8'(a), 8'h00);
    end
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs well under 50000 cycles
  initial begin
    repeat (80000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end

  initial begin
    void'($urandom(45419));
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    all_zero();
    for (int i = 0; i < 6; i++) begin
      rv = 8'($urandom);
      wr(IBA_OFF_RATE_DIV, rv);
      chk(IBA_OFF_RATE_DIV, rv);
    end
    rate_run(8'h00);
    rate_run(8'hC0);
    rate_run(8'h7F);
    rate_run(8'h85);
    for (int i = 0; i < 3; i++) begin
      rate_run({2'($urandom_range(0, 3)), 6'($urandom_range(0, 31))});
    end
    own = 7'($urandom_range(8, 119));
    rv = {2'h0, 6'($urandom_range(0, 23))};
    wr(IBA_OFF_RATE_DIV, rv);
    wr(IBA_OFF_OWN_ADDR, {own, 1'b1});
    chk(IBA_OFF_OWN_ADDR, {own, 1'b0});
    wr(IBA_OFF_CTRL, 8'h80);
    u_iba_peer.call({own ^ 7'h01, 1'b1}, dly);
    cmpn(dly, 0, 0);
    chk(IBA_OFF_IRQ_STAT, 8'h00);
    u_iba_peer.call({own, 1'b1}, dly);
    cmpn(dly, IBA_SDA_HOLD[rv[5:0]] + 1, IBA_SDA_HOLD[rv[5:0]] + 6);
    cmp8({irq, bus_busy, 6'h00}, 8'h00);
    chk(IBA_OFF_IRQ_STAT, 8'h01);
    wr(IBA_OFF_IRQ_EN, 8'h01);
    repeat (3) @(posedge ref_clk);
    cmp8({7'h00, irq}, 8'h01);
    wr(IBA_OFF_IRQ_CLR, 8'h01);
    repeat (3) @(posedge ref_clk);
    cmp8({7'h00, irq}, 8'h00);
    chk(IBA_OFF_IRQ_STAT, 8'h00);
    @(posedge ref_clk);
    stop3_mode <= 1'b1;
    u_iba_peer.call({own, 1'b1}, dly);
    stop3_mode <= 1'b0;
    cmpn(dly, 0, 0);
    chk(IBA_OFF_IRQ_STAT, 8'h00);
    chk(IBA_OFF_OWN_ADDR, {own, 1'b0});
    chk(IBA_OFF_RATE_DIV, rv);
    // Master with data bit low: START on the bus, seen as busy
    wr(IBA_OFF_CTRL, 8'hA0);
    repeat (6) @(posedge ref_clk);
    cmp8({pin_out.sda_oe, bus_busy, pin_out.scl_oe, 5'h00}, 8'hC0);
    wr(IBA_OFF_CTRL, 8'h00);
    wr(IBA_OFF_IRQ_EN, 8'h02);
    wr(IBA_OFF_RATE_DIV, 8'h00);
    wr(IBA_OFF_CTRL, 8'hA1);
    wait_oe(1'b1);
    wait_oe(1'b0);
    u_iba_peer.hold_sda(1'b1);
    repeat (40) @(posedge ref_clk);
    cmp8({pin_out.scl_oe, bus_busy, pin_out.scl_o, pin_out.sda_o, 3'h0, irq}, 8'h41);
    chk(IBA_OFF_IRQ_STAT, 8'h82);
    chk(IBA_OFF_CTRL, 8'h81);
    u_iba_peer.hold_sda(1'b0);
    repeat (8) @(posedge ref_clk);
    cmp8({7'h00, bus_busy}, 8'h00);
    wr(IBA_OFF_IRQ_EN, 8'h03);
    chk(IBA_OFF_IRQ_EN, 8'h03);
    @(posedge ref_clk);
    deep_stop <= 1'b1;
    @(posedge ref_clk);
    deep_stop <= 1'b0;
    all_zero();
    test_done();
  end
endmodule
